// [hdl/cmosc_pkg.sv]
// Purpose: shared constants and types for the CAN object/status controller
// Assumes: 32-bit APB, byte offsets below, one 200 MHz clock
// Notes: field layouts of the coined registers live here
package cmosc_pkg;
  localparam int NOBJ = 32;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_TIMING = 12'h008;
  localparam logic [11:0] OFS_CAUSE = 12'h00C;
  localparam logic [11:0] OFS_OBJIRQ = 12'h010;
  localparam logic [11:0] OFS_TXPEND = 12'h014;
  localparam logic [11:0] OFS_FRESH = 12'h018;
  localparam logic [11:0] OFS_VALID = 12'h01C;
  localparam logic [11:0] OFS_OBJSEL = 12'h020;
  localparam logic [11:0] OFS_OBJID = 12'h024;
  localparam logic [11:0] OFS_OBJMASK = 12'h028;
  localparam logic [11:0] OFS_OBJCFG = 12'h02C;
  // Control bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_ERR_IE = 2;
  localparam int CTRL_STAT_IE = 3;
  // Status bits
  localparam int ST_TXOK = 3;
  localparam int ST_RXOK = 4;
  localparam int ST_WARN = 5;
  localparam int ST_PASSIVE = 6;
  localparam int ST_BUSOFF = 7;
  // Timing field positions, limits and reset values
  localparam int TM_FRONT_LSB = 0;
  localparam int TM_REAR_LSB = 8;
  localparam int TM_SJW_LSB = 12;
  localparam int TM_DIV_LSB = 16;
  localparam logic [9:0] FRONT_MIN = 10'h002;
  localparam logic [9:0] FRONT_MAX = 10'h010;
  localparam logic [9:0] REAR_MIN = 10'h001;
  localparam logic [9:0] REAR_MAX = 10'h008;
  localparam logic [9:0] SJW_MIN = 10'h001;
  localparam logic [9:0] SJW_MAX = 10'h004;
  localparam logic [9:0] DIV_MIN = 10'h001;
  localparam logic [9:0] DIV_MAX = 10'h3FF;
  localparam logic [4:0] FRONT_RST = 5'h04;
  localparam logic [3:0] REAR_RST = 4'h2;
  localparam logic [2:0] SJW_RST = 3'h1;
  localparam logic [9:0] DIV_RST = 10'h001;
  // Last error codes
  localparam logic [2:0] LEC_NONE = 3'h0;
  localparam logic [2:0] LEC_STUFF = 3'h1;
  localparam logic [2:0] LEC_FORM = 3'h2;
  localparam logic [2:0] LEC_ACK = 3'h3;
  localparam logic [2:0] LEC_HELD1 = 3'h4;
  localparam logic [2:0] LEC_HELD0 = 3'h5;
  localparam logic [2:0] LEC_CRC = 3'h6;
  // Object types
  localparam logic [2:0] TYP_TX_DATA = 3'h0;
  localparam logic [2:0] TYP_TX_REMOTE = 3'h1;
  localparam logic [2:0] TYP_RX_DATA = 3'h2;
  localparam logic [2:0] TYP_RX_REMOTE = 3'h3;
  localparam logic [2:0] TYP_AUTO_ANSWER = 3'h4;
  // Object configuration bits
  localparam int CF_LONG = 0;
  localparam int CF_IDF = 1;
  localparam int CF_DIRF = 2;
  localparam int CF_LONGF = 3;
  localparam int CF_RXIE = 4;
  localparam int CF_TXIE = 5;
  localparam int CF_CHAIN = 6;
  localparam int CF_VALID = 7;
  localparam int CF_TXREQ = 8;
  localparam int CF_TYPE_LSB = 9;
  localparam int CF_FRESH = 12;
  localparam int CF_OVR = 13;
  localparam int CF_IRQ = 14;
  localparam logic [15:0] CAUSE_STATUS = 16'h8000;
  // Received frame summary from the serial engine
  typedef struct packed {
    logic [28:0] id;
    logic ext;
    logic remote;
  } cmosc_rx_s;
  typedef enum logic [2:0] {
    SEG_SYNC = 3'b001,
    SEG_FRONT = 3'b010,
    SEG_REAR = 3'b100
  } cmosc_seg_e;
endpackage : cmosc_pkg

// [hdl/cmosc_top.sv]
// Purpose: CAN bit timing, message-object flags, interrupt gating and status
// Assumes: serial engine runs on pclk and gives one-cycle event pulses
// Notes: APB slave with one wait state, object fields via a selection window
module cmosc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_done,
  input wire cmosc_pkg::cmosc_rx_s rx_frame,
  input wire logic tx_done,
  input wire logic [4:0] tx_done_obj,
  input wire logic err_event,
  input wire logic [2:0] err_code,
  input wire logic warn_level,
  input wire logic passive_level,
  input wire logic busoff_level,
  input wire logic resync_early,
  input wire logic resync_late,
  output logic ctrl_enable,
  output logic tx_request,
  output logic [4:0] tx_object,
  output logic irq,
  output logic tq_tick,
  output logic sample_point,
  output logic bit_start
);
  // Lowest set bit of a 32-bit map
  function automatic logic [4:0] first_set(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : first_set

  // Hold a value inside its legal range
  function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp10

  logic pready_ff, pslverr_ff, irq_ff, tq_ff, sample_ff, bitst_ff, txr_ff;
  logic [31:0] prdata_ff, rd_word, match;
  logic [4:0] txo_ff, sel_ff, front_ff, hidx, q_cnt_ff, seg_len_ff;
  logic [3:0] ctrl_ff, rear_ff;
  logic [2:0] sjw_ff, lec_ff;
  logic [9:0] div_ff, div_cnt_ff;
  logic rx_ok_ff, tx_ok_ff, stat_pend_ff, err_pend_ff, ext_done_ff, cut_done_ff;
  logic [2:0] lvl_ff;
  logic acc, wr, rd, mapped, hit, st_rd, obj_rd;
  logic [28:0] id_mem [cmosc_pkg::NOBJ];
  logic [28:0] mask_mem [cmosc_pkg::NOBJ];
  logic [2:0] type_mem [cmosc_pkg::NOBJ];
  logic [31:0] long_v, idf_v, dirf_v, longf_v, rxie_v, txie_v, chain_v, valid_v;
  logic [31:0] txreq_v, fresh_v, ovr_v, oirq_v;
  cmosc_pkg::cmosc_seg_e seg_ff;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign tq_tick = tq_ff;
  assign sample_point = sample_ff;
  assign bit_start = bitst_ff;
  assign tx_request = txr_ff;
  assign tx_object = txo_ff;
  assign ctrl_enable = ctrl_ff[cmosc_pkg::CTRL_EN];

  // APB decode; the access completes when pready_ff is high
  assign acc = psel & penable & pready_ff;
  assign wr = acc & pwrite & mapped;
  assign rd = acc & ~pwrite & mapped;
  assign st_rd = rd & (paddr == cmosc_pkg::OFS_STATUS);
  assign obj_rd = rd & (paddr == cmosc_pkg::OFS_OBJCFG);
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= cmosc_pkg::OFS_OBJCFG);

  // One wait state, read data and error registered on the same edge as pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~mapped;
      if (psel & penable & ~pready_ff & ~pwrite) begin
        prdata_ff <= mapped ? rd_word : 32'h0000_0000;
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      cmosc_pkg::OFS_CTRL: rd_word[3:0] = ctrl_ff;
      cmosc_pkg::OFS_STATUS: rd_word[7:0] = {busoff_level, passive_level, warn_level,
                                             rx_ok_ff, tx_ok_ff, lec_ff};
      cmosc_pkg::OFS_TIMING: rd_word = {6'h00, div_ff, 1'b0, sjw_ff, rear_ff, 3'h0, front_ff};
      cmosc_pkg::OFS_CAUSE: begin
        if (|oirq_v) begin
          rd_word[5:0] = {1'b0, first_set(oirq_v)} + 6'h01;
        end else if (stat_pend_ff | err_pend_ff) begin
          rd_word[15:0] = cmosc_pkg::CAUSE_STATUS;
        end
      end
      cmosc_pkg::OFS_OBJIRQ: rd_word = oirq_v;
      cmosc_pkg::OFS_TXPEND: rd_word = txreq_v;
      cmosc_pkg::OFS_FRESH: rd_word = fresh_v;
      cmosc_pkg::OFS_VALID: rd_word = valid_v;
      cmosc_pkg::OFS_OBJSEL: rd_word[4:0] = sel_ff;
      cmosc_pkg::OFS_OBJID: rd_word[28:0] = id_mem[sel_ff];
      cmosc_pkg::OFS_OBJMASK: rd_word[28:0] = mask_mem[sel_ff];
      cmosc_pkg::OFS_OBJCFG: rd_word[14:0] = {oirq_v[sel_ff], ovr_v[sel_ff], fresh_v[sel_ff],
        type_mem[sel_ff], txreq_v[sel_ff], valid_v[sel_ff], chain_v[sel_ff], txie_v[sel_ff],
        rxie_v[sel_ff], longf_v[sel_ff], dirf_v[sel_ff], idf_v[sel_ff], long_v[sel_ff]};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Control and object selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 4'h0;
      sel_ff <= 5'h00;
    end else begin
      if (wr && paddr == cmosc_pkg::OFS_CTRL) begin
        ctrl_ff <= pwdata[3:0];
      end
      if (wr && paddr == cmosc_pkg::OFS_OBJSEL) begin
        sel_ff <= pwdata[4:0];
      end
    end
  end

  // Bit timing values, clamped into their legal ranges on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front_ff <= cmosc_pkg::FRONT_RST;
      rear_ff <= cmosc_pkg::REAR_RST;
      sjw_ff <= cmosc_pkg::SJW_RST;
      div_ff <= cmosc_pkg::DIV_RST;
    end else if (wr && paddr == cmosc_pkg::OFS_TIMING) begin
      front_ff <= 5'(clamp10({5'h00, pwdata[cmosc_pkg::TM_FRONT_LSB +: 5]},
                             cmosc_pkg::FRONT_MIN, cmosc_pkg::FRONT_MAX));
      rear_ff <= 4'(clamp10({6'h00, pwdata[cmosc_pkg::TM_REAR_LSB +: 4]},
                            cmosc_pkg::REAR_MIN, cmosc_pkg::REAR_MAX));
      sjw_ff <= 3'(clamp10({7'h00, pwdata[cmosc_pkg::TM_SJW_LSB +: 3]},
                           cmosc_pkg::SJW_MIN, cmosc_pkg::SJW_MAX));
      div_ff <= clamp10(pwdata[cmosc_pkg::TM_DIV_LSB +: 10],
                        cmosc_pkg::DIV_MIN, cmosc_pkg::DIV_MAX);
    end
  end

  // Quantum divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_ff <= 10'h000;
      tq_ff <= 1'b0;
    end else if (!ctrl_ff[cmosc_pkg::CTRL_EN]) begin
      div_cnt_ff <= 10'h000;
      tq_ff <= 1'b0;
    end else begin
      tq_ff <= (div_cnt_ff >= div_ff - 10'h001);
      div_cnt_ff <= (div_cnt_ff >= div_ff - 10'h001) ? 10'h000 : div_cnt_ff + 10'h001;
    end
  end

  // Bit segments: one sync quantum, front remainder, rear; jump width resync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_ff <= cmosc_pkg::SEG_SYNC;
      q_cnt_ff <= 5'h00;
      seg_len_ff <= 5'h01;
      sample_ff <= 1'b0;
      bitst_ff <= 1'b0;
      ext_done_ff <= 1'b0;
      cut_done_ff <= 1'b0;
    end else begin
      sample_ff <= 1'b0;
      bitst_ff <= 1'b0;
      if (seg_ff == cmosc_pkg::SEG_FRONT && resync_late && !ext_done_ff) begin
        seg_len_ff <= seg_len_ff + {2'b00, sjw_ff};
        ext_done_ff <= 1'b1;
      end else if (seg_ff == cmosc_pkg::SEG_REAR && resync_early && !cut_done_ff) begin
        seg_len_ff <= (seg_len_ff > q_cnt_ff + {2'b00, sjw_ff}) ?
                      seg_len_ff - {2'b00, sjw_ff} : q_cnt_ff + 5'h01;
        cut_done_ff <= 1'b1;
      end
      // Quanta keep counting while a resync adjusts the length
      if (tq_ff) begin
        if (q_cnt_ff + 5'h01 >= seg_len_ff) begin
          q_cnt_ff <= 5'h00;
          case (seg_ff)
            cmosc_pkg::SEG_SYNC: begin
              seg_ff <= cmosc_pkg::SEG_FRONT;
              seg_len_ff <= front_ff - 5'h01;
              ext_done_ff <= 1'b0;
            end
            cmosc_pkg::SEG_FRONT: begin
              seg_ff <= cmosc_pkg::SEG_REAR;
              seg_len_ff <= {1'b0, rear_ff};
              sample_ff <= 1'b1;
              cut_done_ff <= 1'b0;
            end
            default: begin
              seg_ff <= cmosc_pkg::SEG_SYNC;
              seg_len_ff <= 5'h01;
              bitst_ff <= 1'b1;
            end
          endcase
        end else begin
          q_cnt_ff <= q_cnt_ff + 5'h01;
        end
      end
    end
  end

  // Acceptance: valid receive object, id match under mask, chain skip
  always_comb begin
    logic [28:0] diff;
    logic typ_ok;
    diff = '0;
    typ_ok = 1'b0;
    for (int i = 0; i < cmosc_pkg::NOBJ; i++) begin
      diff = (rx_frame.id ^ id_mem[i]) & (idf_v[i] ? mask_mem[i] : 29'h1FFF_FFFF);
      if (!dirf_v[i] && idf_v[i]) begin
        typ_ok = type_mem[i] inside {cmosc_pkg::TYP_RX_DATA, cmosc_pkg::TYP_RX_REMOTE,
                                     cmosc_pkg::TYP_AUTO_ANSWER};
      end else if (rx_frame.remote) begin
        typ_ok = type_mem[i] inside {cmosc_pkg::TYP_RX_REMOTE,
                                     cmosc_pkg::TYP_AUTO_ANSWER};
      end else begin
        typ_ok = (type_mem[i] == cmosc_pkg::TYP_RX_DATA);
      end
      match[i] = valid_v[i] && typ_ok && !(chain_v[i] && fresh_v[i])
        && ((idf_v[i] && !longf_v[i]) || rx_frame.ext == long_v[i])
        && (rx_frame.ext ? (diff == 29'h0) : (diff[10:0] == 11'h000));
    end
  end
  assign hit = rx_done & ctrl_ff[cmosc_pkg::CTRL_EN] & (|match);
  assign hidx = first_set(match);

  // Object configuration written through the selection window
  always_ff @(posedge pclk) begin
    if (wr && paddr == cmosc_pkg::OFS_OBJID) begin
      id_mem[sel_ff] <= pwdata[28:0];
    end else if (hit) begin
      id_mem[hidx] <= rx_frame.id;
    end
    if (wr && paddr == cmosc_pkg::OFS_OBJMASK) begin
      mask_mem[sel_ff] <= pwdata[28:0];
    end
    if (wr && paddr == cmosc_pkg::OFS_OBJCFG) begin
      type_mem[sel_ff] <= pwdata[cmosc_pkg::CF_TYPE_LSB +: 3];
    end
  end

  // Static object flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {long_v, idf_v, dirf_v, longf_v} <= '0;
      {rxie_v, txie_v, chain_v, valid_v} <= '0;
    end else if (wr && paddr == cmosc_pkg::OFS_OBJCFG) begin
      long_v[sel_ff] <= pwdata[cmosc_pkg::CF_LONG];
      idf_v[sel_ff] <= pwdata[cmosc_pkg::CF_IDF];
      dirf_v[sel_ff] <= pwdata[cmosc_pkg::CF_DIRF];
      longf_v[sel_ff] <= pwdata[cmosc_pkg::CF_LONGF];
      rxie_v[sel_ff] <= pwdata[cmosc_pkg::CF_RXIE];
      txie_v[sel_ff] <= pwdata[cmosc_pkg::CF_TXIE];
      chain_v[sel_ff] <= pwdata[cmosc_pkg::CF_CHAIN];
      valid_v[sel_ff] <= pwdata[cmosc_pkg::CF_VALID];
    end
  end

  // Dynamic object flags; read clears come first so a same-cycle set wins, a tx_done clear of txreq beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {txreq_v, fresh_v, ovr_v, oirq_v} <= '0;
    end else begin
      if (obj_rd) begin
        fresh_v[sel_ff] <= 1'b0;
        ovr_v[sel_ff] <= 1'b0;
        oirq_v[sel_ff] <= 1'b0;
      end
      if (wr && paddr == cmosc_pkg::OFS_OBJCFG) begin
        txreq_v[sel_ff] <= pwdata[cmosc_pkg::CF_TXREQ];
      end
      if (tx_done) begin
        txreq_v[tx_done_obj] <= 1'b0;
        if (txie_v[tx_done_obj]) begin
          oirq_v[tx_done_obj] <= 1'b1;
        end
      end
      if (hit) begin
        fresh_v[hidx] <= 1'b1;
        if (fresh_v[hidx] && !(obj_rd && sel_ff == hidx)) begin
          ovr_v[hidx] <= 1'b1;
        end
        if (rxie_v[hidx]) begin
          oirq_v[hidx] <= 1'b1;
        end
        if (rx_frame.remote && type_mem[hidx] == cmosc_pkg::TYP_AUTO_ANSWER) begin
          txreq_v[hidx] <= 1'b1;
        end
      end
    end
  end

  // Transmit arbitration: lowest numbered pending valid object
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txr_ff <= 1'b0;
      txo_ff <= 5'h00;
    end else begin
      txr_ff <= ctrl_ff[cmosc_pkg::CTRL_EN] & (|(txreq_v & valid_v));
      txo_ff <= first_set(txreq_v & valid_v);
    end
  end

  // Controller status; a read clears, an event in that cycle still sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ok_ff <= 1'b0;
      tx_ok_ff <= 1'b0;
      stat_pend_ff <= 1'b0;
      err_pend_ff <= 1'b0;
      lec_ff <= cmosc_pkg::LEC_NONE;
      lvl_ff <= 3'h0;
    end else begin
      lvl_ff <= {busoff_level, passive_level, warn_level};
      rx_ok_ff <= hit | (rx_ok_ff & ~st_rd);
      tx_ok_ff <= tx_done | (tx_ok_ff & ~st_rd);
      stat_pend_ff <= hit | tx_done | err_event | (stat_pend_ff & ~st_rd);
      err_pend_ff <= (|({busoff_level, passive_level, warn_level} & ~lvl_ff))
                     | (err_pend_ff & ~st_rd);
      if (err_event) begin
        lec_ff <= err_code;
      end else if (hit | tx_done) begin
        lec_ff <= cmosc_pkg::LEC_NONE;
      end
    end
  end

  // Interrupt gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= ctrl_ff[cmosc_pkg::CTRL_MASTER]
        & ((stat_pend_ff & ctrl_ff[cmosc_pkg::CTRL_STAT_IE])
           | (err_pend_ff & ctrl_ff[cmosc_pkg::CTRL_ERR_IE]) | (|oirq_v));
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_master_gate: assert property (!ctrl_ff[1] ##1 !ctrl_ff[1] |-> !irq_ff)
    else $error("interrupt raised with master enable clear");
  a_class_gate: assert property (ctrl_ff[1] && !ctrl_ff[2] && !ctrl_ff[3] && oirq_v == 32'h0
                                 |=> !irq_ff)
    else $error("class interrupt passed a clear enable");
  a_rxok_hold: assert property (rx_ok_ff && !st_rd |=> rx_ok_ff)
    else $error("receive success dropped without status read");
  a_txok_set: assert property (tx_done |=> tx_ok_ff ##1 (tx_ok_ff || $past(st_rd)))
    else $error("transmit success not held");
  a_overrun_flag: assert property (hit && fresh_v[hidx] && !obj_rd
                                   |=> ovr_v[$past(hidx)])
    else $error("overwrite of unread object not flagged");
  a_front_range: assert property (front_ff >= 5'h02 && front_ff <= 5'h10
                                  && rear_ff >= 4'h1 && rear_ff <= 4'h8)
    else $error("bit timing field out of range");
  a_quantum_div2: assert property (tq_ff && div_ff == 10'h002 && $stable(div_ff)
                                   && ctrl_ff[0] |=> !tq_ff ##1 tq_ff)
    else $error("quantum period wrong for divider two");
  a_status_clear: assert property (st_rd && !hit && !tx_done && !err_event
                                   |=> !rx_ok_ff && !tx_ok_ff && !stat_pend_ff)
    else $error("status read did not clear flags");
  a_apb_wait: assert property (psel && penable && !pready_ff |=> pready_ff)
    else $error("apb access not completed after one wait");
  c_rx_hit: cover property (hit ##1 rx_ok_ff);
  c_auto_answer: cover property (hit && rx_frame.remote ##2 txr_ff);
  c_bit_done: cover property (sample_ff ##[1:200] bitst_ff);
endmodule : cmosc_top

// [bench/cmosc_engine_model.sv]
// Purpose: far-side engine stand-in raising frame, error and level events
// Assumes: events are one-cycle pulses launched after a rising edge
// Notes: frame and object buses show inverted junk outside their pulse
module cmosc_engine_model (
  input wire logic pclk,
  output logic rx_done,
  output cmosc_pkg::cmosc_rx_s rx_frame,
  output logic tx_done,
  output logic [4:0] tx_done_obj,
  output logic err_event,
  output logic [2:0] err_code,
  output logic [2:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet bus at time zero
  initial begin
    {rx_done, tx_done, err_event} = 3'h0;
    rx_frame = '0;
    tx_done_obj = 5'h00;
    err_code = 3'h0;
    lvl = 3'h0;
  end
  // Error-free frame of the given kind
  task rx(input logic [28:0] id, input logic ext, input logic remote);
    @(posedge pclk);
    rx_done <= 1'b1;
    rx_frame <= '{id: id, ext: ext, remote: remote};
    @(posedge pclk);
    rx_done <= 1'b0;
    rx_frame <= ~rx_frame;
  endtask : rx
  // Object sent without error
  task tx(input logic [4:0] obj);
    @(posedge pclk);
    tx_done <= 1'b1;
    tx_done_obj <= obj;
    @(posedge pclk);
    tx_done <= 1'b0;
    tx_done_obj <= ~tx_done_obj;
  endtask : tx
  // Bus error of one kind
  task err(input logic [2:0] code);
    @(posedge pclk);
    err_event <= 1'b1;
    err_code <= code;
    @(posedge pclk);
    err_event <= 1'b0;
    err_code <= ~err_code;
  endtask : err
  // Error levels as the engine reports them
  task levels(input logic [2:0] v);
    @(posedge pclk);
    lvl <= v;
  endtask : levels
endmodule : cmosc_engine_model

// [bench/cmosc_top_tb.sv]
// Purpose: self-checking bench for the CAN object and status block
// Assumes: APB master of one request at a time, 200 MHz clock
// Notes: table rows first, event scenarios after
module cmosc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x;} cmosc_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_done, tx_done, err_event;
  logic ctrl_enable, tx_request, irq, tq_tick, sample_point, bit_start, e;
  logic resync_early, resync_late;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [4:0] tx_done_obj, tx_object;
  logic [2:0] err_code, lvl;
  cmosc_pkg::cmosc_rx_s rx_frame;
  int errors, n_tests;
  int cyc, nq, sp;
  cmosc_row_s rows[$] = '{
    '{1'b0, cmosc_pkg::OFS_TIMING, 32'h0, 32'h0001_1204},
    '{1'b1, cmosc_pkg::OFS_TIMING, 32'h0, 32'h0},
    '{1'b0, cmosc_pkg::OFS_TIMING, 32'h0, 32'h0001_1102},
    '{1'b1, cmosc_pkg::OFS_TIMING, 32'h03FF_7F1F, 32'h0},
    '{1'b0, cmosc_pkg::OFS_TIMING, 32'h0, 32'h03FF_4810},
    '{1'b1, cmosc_pkg::OFS_TIMING, 32'h0002_1204, 32'h0},
    '{1'b0, cmosc_pkg::OFS_TIMING, 32'h0, 32'h0002_1204},
    '{1'b1, cmosc_pkg::OFS_CTRL, 32'h3, 32'h0},
    '{1'b1, cmosc_pkg::OFS_OBJSEL, 32'h3, 32'h0},
    '{1'b1, cmosc_pkg::OFS_OBJID, 32'h123, 32'h0},
    '{1'b1, cmosc_pkg::OFS_OBJCFG, 32'h490, 32'h0},
    '{1'b0, cmosc_pkg::OFS_OBJCFG, 32'h0, 32'h490},
    '{1'b1, cmosc_pkg::OFS_OBJSEL, 32'h7, 32'h0},
    '{1'b1, cmosc_pkg::OFS_OBJCFG, 32'h180, 32'h0},
    '{1'b1, cmosc_pkg::OFS_OBJSEL, 32'h5, 32'h0},
    '{1'b1, cmosc_pkg::OFS_OBJCFG, 32'h180, 32'h0},
    '{1'b0, cmosc_pkg::OFS_VALID, 32'h0, 32'hA8},
    '{1'b0, cmosc_pkg::OFS_TXPEND, 32'h0, 32'hA0}};
  cmosc_top cmosc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_done(rx_done), .rx_frame(rx_frame), .tx_done(tx_done),
    .tx_done_obj(tx_done_obj), .err_event(err_event), .err_code(err_code),
    .warn_level(lvl[2]), .passive_level(lvl[1]), .busoff_level(lvl[0]),
    .resync_early(resync_early), .resync_late(resync_late), .ctrl_enable(ctrl_enable),
    .tx_request(tx_request), .tx_object(tx_object), .irq(irq), .tq_tick(tq_tick),
    .sample_point(sample_point), .bit_start(bit_start));
  cmosc_engine_model cmosc_engine_model_inst (.pclk(pclk), .rx_done(rx_done),
    .rx_frame(rx_frame), .tx_done(tx_done), .tx_done_obj(tx_done_obj),
    .err_event(err_event), .err_code(err_code), .lvl(lvl));
  // Verdict and end of run
  task conclude;
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  // Compare one value
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("mismatch %s expected %h seen %h", nm, x, g);
      errors++;
    end
  endtask : chk
  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      errors++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Read and compare
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, r);
  endtask : rd
  // Cycles, quanta and sample offset up to the next bit start; optional resync pulses
  task gap(input int late_at, input int early_at, output int c, output int q, output int s);
    c = 0;
    q = 0;
    s = 0;
    do begin
      @(posedge pclk);
      c++;
      if (tq_tick === 1'b1) q++;
      if (sample_point === 1'b1) s = c;
      resync_late <= (c == late_at);
      resync_early <= (c == early_at);
    end while (bit_start !== 1'b1 && c < 100);
  endtask : gap
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    conclude();
  end
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, errors, n_tests} = '0;
    {resync_early, resync_late} = 2'b00;
    repeat (4) @(posedge pclk);
    chk("irq", 32'h0, irq);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("prdata", rows[i].x, r);
    end
    chk("ctrl_enable", 32'h1, ctrl_enable);
    gap(0, 0, cyc, nq, sp);
    gap(0, 0, cyc, nq, sp);
    chk("bit cycles", 32'd12, cyc);
    chk("quanta", 32'd6, nq);
    chk("sample offset", 32'd8, sp);
    gap(1, 0, cyc, nq, sp);
    chk("late bit cycles", 32'd14, cyc);
    chk("late quanta", 32'd7, nq);
    chk("late sample offset", 32'd10, sp);
    gap(0, 7, cyc, nq, sp);
    chk("early bit cycles", 32'd10, cyc);
    chk("early quanta", 32'd5, nq);
    chk("early sample offset", 32'd8, sp);
    apb(1'b1, cmosc_pkg::OFS_OBJSEL, 32'h9);
    for (int t = 0; t < 5; t++) begin
      apb(1'b1, cmosc_pkg::OFS_OBJCFG, 32'(t << 9) | 32'h40);
      rd(cmosc_pkg::OFS_OBJCFG, 32'(t << 9) | 32'h40);
    end
    apb(1'b0, 12'h030, 32'h0);
    chk("pslverr", 32'h1, e);
    @(negedge pclk);
    chk("tx_object", 32'h5, tx_object);
    chk("tx_request", 32'h1, tx_request);
    cmosc_engine_model_inst.rx(29'h123, 1'b0, 1'b0);
    cmosc_engine_model_inst.rx(29'h123, 1'b0, 1'b0);
    repeat (2) @(negedge pclk);
    chk("irq", 32'h1, irq);
    rd(cmosc_pkg::OFS_CAUSE, 32'h4);
    rd(cmosc_pkg::OFS_FRESH, 32'h8);
    apb(1'b1, cmosc_pkg::OFS_OBJSEL, 32'h3);
    rd(cmosc_pkg::OFS_OBJCFG, 32'h7490);
    rd(cmosc_pkg::OFS_FRESH, 32'h0);
    @(negedge pclk);
    chk("irq", 32'h0, irq);
    rd(cmosc_pkg::OFS_STATUS, 32'h10);
    rd(cmosc_pkg::OFS_STATUS, 32'h0);
    apb(1'b1, cmosc_pkg::OFS_CTRL, 32'hD);
    cmosc_engine_model_inst.err(cmosc_pkg::LEC_CRC);
    repeat (3) @(negedge pclk);
    chk("irq", 32'h0, irq);
    apb(1'b1, cmosc_pkg::OFS_CTRL, 32'hF);
    repeat (2) @(negedge pclk);
    chk("irq", 32'h1, irq);
    rd(cmosc_pkg::OFS_STATUS, 32'h6);
    repeat (2) @(negedge pclk);
    chk("irq", 32'h0, irq);
    cmosc_engine_model_inst.tx(5'h05);
    rd(cmosc_pkg::OFS_STATUS, 32'h8);
    rd(cmosc_pkg::OFS_TXPEND, 32'h80);
    @(negedge pclk);
    chk("tx_object", 32'h7, tx_object);
    cmosc_engine_model_inst.levels(3'h7);
    rd(cmosc_pkg::OFS_STATUS, 32'hE0);
    apb(1'b1, cmosc_pkg::OFS_OBJSEL, 32'h9);
    apb(1'b1, cmosc_pkg::OFS_OBJMASK, 32'h0F0);
    apb(1'b1, cmosc_pkg::OFS_OBJID, 32'h1A5);
    apb(1'b1, cmosc_pkg::OFS_OBJCFG, 32'h886);
    cmosc_engine_model_inst.rx(29'h0B0, 1'b0, 1'b1);
    rd(cmosc_pkg::OFS_FRESH, 32'h0);
    cmosc_engine_model_inst.rx(29'h0A7, 1'b0, 1'b1);
    rd(cmosc_pkg::OFS_TXPEND, 32'h280);
    rd(cmosc_pkg::OFS_OBJID, 32'h0A7);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("tx_request", 32'h0, tx_request);
    presetn <= 1'b1;
    rd(cmosc_pkg::OFS_TIMING, 32'h0001_1204);
    conclude();
  end
endmodule : cmosc_top_tb
